// >>> rtl/scps_consts.vh
// Constants for the serial channel pin select block
`ifndef SCPS_CONSTS_VH
`define SCPS_CONSTS_VH
// Register offsets (byte addresses on the plain register port)
`define SCPS_OFS_CH8_11 8'h00
`define SCPS_OFS_CH12_15 8'h04
// Field layout: channel group k (0..3 from the low end) at bit 4+6k
`define SCPS_GRP_BASE 4
`define SCPS_GRP_WIDTH 6
`define SCPS_CLK_POS 4
`define SCPS_DOUT_POS 2
`define SCPS_DIN_POS 0
// Writable field mask: bits 27..4
`define SCPS_FIELD_MASK 32'h0FFF_FFF0
// Reset value of both registers
`define SCPS_REG_RST 32'h0000_0000
// Select encodings
`define SCPS_SEL_NONE 2'h0
`define SCPS_SEL_OPT0 2'h1
`define SCPS_SEL_OPT1 2'h2
`define SCPS_SEL_OPT2 2'h3
`endif

// >>> rtl/scps_chan_route.v
// Pin routing for one serial channel: clock, data out, data in
`timescale 1ns/1ps
`default_nettype none
`include "scps_consts.vh"
module scps_chan_route (
  input wire [5:0] sel, // Clock, data-out, data-in selects, high to low
  input wire core_clk_out, // Clock driven by the channel
  input wire core_dout, // Data driven by the channel
  output reg core_clk_in, // Clock seen by the channel
  output reg core_din, // Data seen by the channel
  output reg core_dout_rb, // Data-out line level seen by the channel
  input wire [2:0] clk_pin_in, // Clock pin levels, options 0..2
  output reg [2:0] clk_pin_out, // Clock pin drive values
  output reg [2:0] clk_pin_oe, // Clock pin enables
  input wire [2:0] dout_pin_in, // Data-out pin levels
  output reg [2:0] dout_pin_out, // Data-out pin drive values
  output reg [2:0] dout_pin_oe, // Data-out pin enables
  input wire [2:0] din_pin_in // Data-in pin levels
);
  wire [1:0] clk_sel;
  wire [1:0] dout_sel;
  wire [1:0] din_sel;
  assign clk_sel = sel[`SCPS_CLK_POS+1:`SCPS_CLK_POS];
  assign dout_sel = sel[`SCPS_DOUT_POS+1:`SCPS_DOUT_POS];
  assign din_sel = sel[`SCPS_DIN_POS+1:`SCPS_DIN_POS];

  // --------------------------------------------------------------
  // Clock line
  // --------------------------------------------------------------
  always @* begin
    clk_pin_out = 3'h0;
    clk_pin_oe = 3'h0;
    core_clk_in = 1'b0;
    case (clk_sel)
      `SCPS_SEL_NONE: begin
        core_clk_in = clk_pin_in[0]; // [R01]
      end
      `SCPS_SEL_OPT0: begin
        core_clk_in = clk_pin_in[0]; // [R02]
        clk_pin_oe[0] = 1'b1; // [R02]
        clk_pin_out[0] = core_clk_out;
      end
      `SCPS_SEL_OPT1: begin
        core_clk_in = clk_pin_in[1]; // [R03]
        clk_pin_oe[1] = 1'b1; // [R03]
        clk_pin_out[1] = core_clk_out;
      end
      default: begin
        core_clk_in = clk_pin_in[2]; // [R04]
        clk_pin_oe[2] = 1'b1; // [R04]
        clk_pin_out[2] = core_clk_out;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Data-out line, same encoding as the clock
  // --------------------------------------------------------------
  always @* begin
    dout_pin_out = 3'h0; // [R15]
    dout_pin_oe = 3'h0;
    core_dout_rb = 1'b0;
    case (dout_sel)
      `SCPS_SEL_NONE: begin
        core_dout_rb = dout_pin_in[0]; // [R05]
      end
      `SCPS_SEL_OPT0: begin
        core_dout_rb = dout_pin_in[0]; // [R05]
        dout_pin_oe[0] = 1'b1;
        dout_pin_out[0] = core_dout;
      end
      `SCPS_SEL_OPT1: begin
        core_dout_rb = dout_pin_in[1]; // [R05]
        dout_pin_oe[1] = 1'b1;
        dout_pin_out[1] = core_dout;
      end
      default: begin
        core_dout_rb = dout_pin_in[2]; // [R05]
        dout_pin_oe[2] = 1'b1;
        dout_pin_out[2] = core_dout;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Data-in line
  // --------------------------------------------------------------
  always @* begin
    case (din_sel)
      `SCPS_SEL_OPT1: begin
        core_din = din_pin_in[1]; // [R07]
      end
      `SCPS_SEL_OPT2: begin
        core_din = din_pin_in[2]; // [R07]
      end
      default: begin
        core_din = din_pin_in[0]; // [R06]
      end
    endcase
  end
endmodule // scps_chan_route
`default_nettype wire

// >>> rtl/scps_top.v
// Pin select registers and routing for serial channels 8 to 15
`timescale 1ns/1ps
`default_nettype none
`include "scps_consts.vh"
// Contract
// R01: Clock select 00: clock input from option 0, no clock driven.
// R02: Clock select 01: option 0 is clock input and output.
// R03: Clock select 10: option 1 is clock input and output.
// R04: Clock select 11: option 2 is clock input and output.
// R05: Data-out select uses clock encoding; 00 input only from option 0.
// R06: Data-in select 00 or 01 routes option 0.
// R07: Data-in select 10 routes option 1, 11 routes option 2.
// R08: First register: channel 11 at bits 27..22, then 10, 9, 8 below.
// R09: Second register: same layout for channels 15 down to 12.
// R10: Reserved bits 31..28 and 3..0 always read zero.
// R11: Software writes zeros to the reserved bits.
// R12: All select fields reset to 00.
// R13: Deep-standby reset leaves both registers unchanged.
// R14: Reads return stored field values with no side effects.
// R15: Unchosen pin options get no drive and do not reach the channel.
module scps_top #(
  parameter NUM_CH = 8 // Channels 8..15
) (
  input wire ref_clk, // System bus clock
  input wire rst_n, // Ordinary reset, synchronous, active low
  input wire deep_stby_rst_n, // Deep-standby reset, active low
  input wire [7:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata_ff, // Read data, one cycle after strobe
  input wire [NUM_CH-1:0] core_clk_out, // Channel clocks to drive
  input wire [NUM_CH-1:0] core_dout, // Channel data to drive
  output wire [NUM_CH-1:0] core_clk_in, // Clocks to channels
  output wire [NUM_CH-1:0] core_din, // Data to channels
  output wire [NUM_CH-1:0] core_dout_rb, // Data-out line levels
  input wire [3*NUM_CH-1:0] clk_pin_in, // Clock pins, 3 per channel
  output wire [3*NUM_CH-1:0] clk_pin_out, // Clock pin values
  output wire [3*NUM_CH-1:0] clk_pin_oe, // Clock pin enables
  input wire [3*NUM_CH-1:0] dout_pin_in, // Data-out pins
  output wire [3*NUM_CH-1:0] dout_pin_out, // Data-out pin values
  output wire [3*NUM_CH-1:0] dout_pin_oe, // Data-out pin enables
  input wire [3*NUM_CH-1:0] din_pin_in // Data-in pins
);
  // --------------------------------------------------------------
  // Selection registers
  // --------------------------------------------------------------
  reg [31:0] sel_lo_ff;
  reg [31:0] sel_hi_ff;
  reg [31:0] nxt_sel_lo;
  reg [31:0] nxt_sel_hi;
  reg [31:0] nxt_rdata;
  wire hit_lo;
  wire hit_hi;

  assign hit_lo = (reg_addr == `SCPS_OFS_CH8_11);
  assign hit_hi = (reg_addr == `SCPS_OFS_CH12_15);

  // Reserved bits are masked off on write so they can never read back
  always @* begin
    nxt_sel_lo = sel_lo_ff;
    nxt_sel_hi = sel_hi_ff;
    if (reg_wr && hit_lo) begin
      nxt_sel_lo = reg_wdata & `SCPS_FIELD_MASK; // [R08] [R10]
    end else if (reg_wr && hit_hi) begin
      nxt_sel_hi = reg_wdata & `SCPS_FIELD_MASK; // [R09] [R10]
    end
  end

  // Deep-standby reset is accepted as a port but deliberately not used
  // here: the selections survive it.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_lo_ff <= `SCPS_REG_RST; // [R12] [R13]
      sel_hi_ff <= `SCPS_REG_RST; // [R12]
    end else begin
      sel_lo_ff <= nxt_sel_lo;
      sel_hi_ff <= nxt_sel_hi;
    end
  end

  // --------------------------------------------------------------
  // Read port: unmapped addresses return zero
  // --------------------------------------------------------------
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd && hit_lo) begin
      nxt_rdata = sel_lo_ff & `SCPS_FIELD_MASK; // [R14] [R10]
    end else if (reg_rd && hit_hi) begin
      nxt_rdata = sel_hi_ff & `SCPS_FIELD_MASK; // [R14] [R10]
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------
  // Per-channel routing
  // --------------------------------------------------------------
  wire [63:0] all_sel;
  assign all_sel = {sel_hi_ff, sel_lo_ff};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
      // Channel 8+gi: register gi/4, group gi%4 from the low end
      scps_chan_route u_route (
        .sel(all_sel[32*(gi/4) + `SCPS_GRP_BASE + `SCPS_GRP_WIDTH*(gi%4)
             +: 6]), // [R08] [R09]
        .core_clk_out(core_clk_out[gi]),
        .core_dout(core_dout[gi]),
        .core_clk_in(core_clk_in[gi]),
        .core_din(core_din[gi]),
        .core_dout_rb(core_dout_rb[gi]),
        .clk_pin_in(clk_pin_in[3*gi +: 3]),
        .clk_pin_out(clk_pin_out[3*gi +: 3]),
        .clk_pin_oe(clk_pin_oe[3*gi +: 3]),
        .dout_pin_in(dout_pin_in[3*gi +: 3]),
        .dout_pin_out(dout_pin_out[3*gi +: 3]),
        .dout_pin_oe(dout_pin_oe[3*gi +: 3]),
        .din_pin_in(din_pin_in[3*gi +: 3])
      );
    end
  endgenerate
endmodule // scps_top
`default_nettype wire

// >>> testbench/scps_props.sv
// Port assertions for the serial channel pin select block
`timescale 1ns/1ps
`default_nettype none
`include "scps_consts.vh"
module scps_props #(
  parameter NUM_CH = 8 // Channels
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [31:0] reg_rdata_ff, // Read data
  input wire logic [NUM_CH-1:0] core_clk_out, // Channel clocks
  input wire logic [3*NUM_CH-1:0] clk_pin_out, // Clock pins
  input wire logic [3*NUM_CH-1:0] clk_pin_oe, // Clock enables
  input wire logic [3*NUM_CH-1:0] dout_pin_oe // Data enables
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rsvd_zero_a: assert property (
    {reg_rdata_ff[31:28], reg_rdata_ff[3:0]} == 8'h00)
    else $error("reserved bits set");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
    else $error("read data outside slot");
  ch8_clk_a: assert property (
    reg_wr && reg_addr == `SCPS_OFS_CH8_11 |=>
    clk_pin_oe[2:0] == (4'h1 << $past(reg_wdata[9:8])) >> 1)
    else $error("ch8 clock enable wrong");
  ch15_dout_a: assert property (
    reg_wr && reg_addr == `SCPS_OFS_CH12_15 |=>
    dout_pin_oe[3*NUM_CH-1 -: 3] == (4'h1 << $past(reg_wdata[25:24])) >> 1)
    else $error("ch15 data enable wrong");
  hold_a: assert property (
    !reg_wr |=> $stable(clk_pin_oe) && $stable(dout_pin_oe))
    else $error("routing changed without write");
  reset_a: assert property (
    disable iff (1'b0) !rst_n |=> (clk_pin_oe | dout_pin_oe) == 0)
    else $error("pin driven after reset");
  for (genvar g = 0; g < NUM_CH; g = g + 1) begin : g_ch
    one_pin_a: assert property (
      $onehot0(clk_pin_oe[3*g +: 3]) && $onehot0(dout_pin_oe[3*g +: 3]))
      else $error("two pins driven");
    clk_val_a: assert property (
      clk_pin_out[3*g +: 3] == ({3{core_clk_out[g]}} & clk_pin_oe[3*g +: 3]))
      else $error("clock pin value wrong");
  end
  cover property (reg_wr && reg_addr == `SCPS_OFS_CH12_15);
  cover property (reg_rd ##1 reg_rd);
  cover property (clk_pin_oe[2] && dout_pin_oe[3*NUM_CH-1]);
endmodule // scps_props
`default_nettype wire

// >>> testbench/scps_bench.sv
// Self-checking bench for the serial channel pin select block
`timescale 1ns/1ps
`default_nettype none
`include "scps_consts.vh"
module scps_bench;
  logic ref_clk = 1'b0, rst_n = 1'b0, deep_stby_rst_n = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic [7:0] reg_addr = 8'h00, core_clk_out = 8'h00, core_dout = 8'h00;
  logic [31:0] reg_wdata = 32'h0, r0 = 32'h0, r1 = 32'h0, wd, exp_q[$];
  logic [23:0] clk_pin_in = 24'h0, dout_pin_in = 24'h0, din_pin_in = 24'h0;
  wire [31:0] reg_rdata_ff;
  wire [7:0] core_clk_in, core_din, core_dout_rb;
  wire [23:0] clk_pin_out, clk_pin_oe, dout_pin_out, dout_pin_oe;
  integer errors = 0, total_checks = 0, seed = 25141, i, k;
  always #4 ref_clk = ~ref_clk;
  scps_top #(.NUM_CH(8)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .deep_stby_rst_n(deep_stby_rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .core_clk_out(core_clk_out),
    .core_dout(core_dout), .core_clk_in(core_clk_in), .core_din(core_din),
    .core_dout_rb(core_dout_rb), .clk_pin_in(clk_pin_in),
    .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .dout_pin_in(dout_pin_in), .dout_pin_out(dout_pin_out),
    .dout_pin_oe(dout_pin_oe), .din_pin_in(din_pin_in));
  task chk(input [143:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Expected read data is noted when the read is issued
  task bus(input w, r, input [7:0] a, input [31:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
    if (r) exp_q.push_back(a == `SCPS_OFS_CH8_11 ? r0 :
      a == `SCPS_OFS_CH12_15 ? r1 : 32'h0);
    if (w && a == `SCPS_OFS_CH8_11) r0 = d & `SCPS_FIELD_MASK;
    if (w && a == `SCPS_OFS_CH12_15) r1 = d & `SCPS_FIELD_MASK;
    @(posedge ref_clk);
  endtask
  task route_chk;
    logic [5:0] s;
    logic [23:0] eco, ecv, edo, edv;
    logic [7:0] eci, edi, edr;
    {reg_wr, reg_rd} <= 2'b00;
    {clk_pin_in, dout_pin_in, din_pin_in, core_clk_out, core_dout} <=
      88'({$random(seed), $random(seed), $random(seed)});
    #1;
    for (k = 0; k < 8; k = k + 1) begin
      s = k < 4 ? r0[4+6*k +: 6] : r1[6*k-20 +: 6];
      eco[3*k +: 3] = 3'((4'h1 << s[5:4]) >> 1);
      ecv[3*k +: 3] = eco[3*k +: 3] & {3{core_clk_out[k]}};
      edo[3*k +: 3] = 3'((4'h1 << s[3:2]) >> 1);
      edv[3*k +: 3] = edo[3*k +: 3] & {3{core_dout[k]}};
      eci[k] = clk_pin_in[3*k + s[5:4] - (s[5:4] != 2'h0)];
      edr[k] = dout_pin_in[3*k + s[3:2] - (s[3:2] != 2'h0)];
      edi[k] = din_pin_in[3*k + s[1:0] - (s[1:0] != 2'h0)];
    end
    chk({24'h0, clk_pin_oe, clk_pin_out, dout_pin_oe, dout_pin_out,
      core_clk_in, core_din, core_dout_rb},
      {24'h0, eco, ecv, edo, edv, eci, edi, edr});
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (rd_seen) chk({112'h0, reg_rdata_ff},
      {112'h0, exp_q.pop_front()});
    rd_seen <= reg_rd;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    route_chk;
    bus(1'b0, 1'b1, `SCPS_OFS_CH8_11, 32'h0);
    // First four passes set every code in every field; software keeps
    // the reserved bits at zero
    for (i = 0; i < 12; i = i + 1) begin
      wd = (i < 4 ? {4'h0, {12{i[1:0]}}, 4'h0} : $random(seed)) &
        `SCPS_FIELD_MASK;
      bus(1'b1, 1'b0, `SCPS_OFS_CH8_11, wd);
      bus(1'b1, 1'b0, `SCPS_OFS_CH12_15, ~wd & `SCPS_FIELD_MASK);
      bus(1'b0, 1'b1, `SCPS_OFS_CH8_11, 32'h0);
      bus(1'b0, 1'b1, `SCPS_OFS_CH12_15, 32'h0);
      route_chk;
    end
    bus(1'b1, 1'b0, 8'h08, 32'hFFFF_FFFF);
    bus(1'b0, 1'b1, 8'h08, 32'h0);
    route_chk;
    deep_stby_rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    deep_stby_rst_n <= 1'b1;
    bus(1'b0, 1'b1, `SCPS_OFS_CH12_15, 32'h0);
    route_chk;
    rst_n <= 1'b0;
    {r0, r1} = 64'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, 1'b1, `SCPS_OFS_CH8_11, 32'h0);
    route_chk;
    repeat (2) @(posedge ref_clk);
    print_verdict;
  end
  initial begin
    #100000 errors++;
    print_verdict;
  end
endmodule // scps_bench
bind scps_top scps_props #(.NUM_CH(NUM_CH)) u_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .core_clk_out(core_clk_out), .clk_pin_out(clk_pin_out),
  .clk_pin_oe(clk_pin_oe), .dout_pin_oe(dout_pin_oe));
`default_nettype wire
